// ==== rtl/ctc_pkg.sv ====
// Shared constants and types for the communication timing config block.
// Assumes a 200 MHz system clock; all times are turned into cycles here.
package ctc_pkg;

    // Active protocol front end
    typedef enum logic [1:0] {
        CTC_DSI3,
        CTC_PSI5,
        CTC_SPI,
        CTC_I2C
    } ctc_mode_e;

    // Register map (byte addresses on the internal register port)
    localparam logic [7:0] ADDR_CHIP_BIT_TIME     = 8'h23;
    localparam logic [7:0] ADDR_TIMING_CONFIG_TWO = 8'h24;
    localparam logic [7:0] RST_CHIP_BIT_TIME      = 8'h00;
    localparam logic [7:0] RST_TIMING_CONFIG_TWO  = 8'h00;

    // Field positions of chip_bit_time
    localparam int CBT_SELFTEST_LSB = 6;
    localparam int CBT_FAULT_LATCH  = 5;
    localparam int CBT_SIM_SAMPLE   = 4;
    localparam int CBT_CODE_LSB     = 0;
    // Field positions of timing_config_two
    localparam int TC2_PHASE2_BIT   = 7;
    localparam int TC2_TRAIN_LSB    = 4;
    localparam int TC2_CAPTEST_BIT  = 3;
    localparam int TC2_RESERVED_BIT = 2;
    localparam int TC2_FRAG_BIT     = 1;
    localparam int TC2_BDIAG_BIT    = 0;
    // Writable bits of timing_config_two; the reserved bit is dropped
    localparam logic [7:0] TC2_WRITE_MASK = 8'hFB;

    // Source slots addressed by SPI sensor data requests
    localparam int NUM_SRC = 8;

    typedef struct packed {
        logic [1:0] selftest_repeat_count;
        logic       fault_latch_enable;
        logic       sim_sample_select;
        logic [3:0] chip_period_code;
    } ctc_chip_bit_time_s;

    typedef struct packed {
        logic       phase2_nibble_select;
        logic [2:0] training_error_window;
        logic       buffer_cap_test_disable;
        logic       reserved;
        logic       diag_fragment_size;
        logic       background_diag_enable;
    } ctc_timing_config_two_s;

    // Link timing handed to the protocol transmitters
    typedef struct packed {
        logic [10:0] chip_cycles;
        logic        slew_en;
        logic        psi5_slow_rate;
    } ctc_link_timing_s;

    // Clock and timing figures
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int CRM_CHIP_TIME_NS  = 5000;
    localparam int PSI5_FAST_BIT_NS  = 5300;
    localparam int PSI5_SLOW_BIT_NS  = 8000;
    localparam int CHIP_TENTH_NS     = 100;
    localparam logic [10:0] CRM_CHIP_CYCLES =
        11'(CRM_CHIP_TIME_NS * 1000 / CLK_PERIOD_PS);
    localparam logic [10:0] PSI5_FAST_CYCLES =
        11'(PSI5_FAST_BIT_NS * 1000 / CLK_PERIOD_PS);
    localparam logic [10:0] PSI5_SLOW_CYCLES =
        11'(PSI5_SLOW_BIT_NS * 1000 / CLK_PERIOD_PS);
    localparam logic [10:0] TENTH_CYCLES =
        11'(CHIP_TENTH_NS * 1000 / CLK_PERIOD_PS);

    // DSI3 chip time per code, in tenths of a microsecond
    localparam logic [5:0] DSI3_CHIP_TENTHS [16] = '{
        6'h0A, 6'h14, 6'h19, 6'h1A, 6'h1A, 6'h1B, 6'h1C, 6'h1D,
        6'h1E, 6'h1F, 6'h20, 6'h21, 6'h23, 6'h28, 6'h2D, 6'h32
    };
    // Highest DSI3 code that runs without slew control
    localparam logic [3:0] DSI3_SLEW_OFF_LAST = 4'h1;

endpackage : ctc_pkg

// ==== rtl/ctc_chip_decode.sv ====
// Chip and bit time decoder: code plus active mode to link timing.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module ctc_chip_decode
(
    input  wire ctc_pkg::ctc_mode_e        i_mode,
    input  wire logic                      i_crm_active,
    input  wire logic [3:0]                i_code,
    output ctc_pkg::ctc_link_timing_s      o_timing
);

    // Table lookup per mode; SPI and I2C get an idle all-zero timing
    always_comb
    begin
        o_timing = '0;
        unique case (i_mode)
            ctc_pkg::CTC_DSI3:
            begin
                if (i_crm_active)
                begin
                    // Command and response frames ignore the code
                    o_timing.chip_cycles = ctc_pkg::CRM_CHIP_CYCLES;
                    o_timing.slew_en     = 1'b1;
                end
                else
                begin
                    o_timing.chip_cycles = 11'(ctc_pkg::DSI3_CHIP_TENTHS[i_code])
                                         * ctc_pkg::TENTH_CYCLES;
                    // Two fastest codes trade edge shaping for speed
                    o_timing.slew_en =
                        (i_code > ctc_pkg::DSI3_SLEW_OFF_LAST);
                end
            end
            ctc_pkg::CTC_PSI5:
            begin
                // Upper half of the code range selects the slow rate
                o_timing.psi5_slow_rate = i_code[3];
                o_timing.chip_cycles    = i_code[3]
                                        ? ctc_pkg::PSI5_SLOW_CYCLES
                                        : ctc_pkg::PSI5_FAST_CYCLES;
                o_timing.slew_en        = 1'b1;
            end
            ctc_pkg::CTC_SPI,
            ctc_pkg::CTC_I2C:
            begin
                o_timing = '0;
            end
        endcase
    end

endmodule : ctc_chip_decode

// ==== rtl/ctc_timing_regs.sv ====
// Chip/bit time and second timing configuration registers, fault
// latching and sample reference selection for all protocol front ends.
// Assumes the active front end decodes register frames into the byte
// port below and raises one-cycle pulses for the timing events.
//
// Operation
// - PSI5 latch enable holds faults until reset
// - Latch enable acts only in PSI5 mode
// - DSI3 synchronous: latency from transmission start
// - DSI3 simultaneous: latency from command falling edge
// - PSI5: slot reference or sync pulse reference
// - SPI synchronous: each source on own request
// - SPI simultaneous: all sources on slot zero
// - Slot zero off: lowest enabled slot instead
// - Higher slots update only on lowest request
// - I2C: sample select stored but ignored
// - DSI3 CRM chip time fixed 5 us, slewed
// - DSI3 code table, two fastest unslewed
// - PSI5 code picks 5.3 or 8.0 us
// - SPI/I2C: chip code stored but ignored
// - Second config register field layout
// - Both registers under array error check
// - Writable except in PSI5 normal mode
// - Chip and bit time register field layout
`timescale 1ns/1ps
module ctc_timing_regs
(
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    input  wire ctc_pkg::ctc_mode_e         i_mode,
    input  wire logic                       i_psi5_prog_mode,
    input  wire logic                       i_wr_en,
    input  wire logic                       i_rd_en,
    input  wire logic [7:0]                 i_addr,
    input  wire logic [7:0]                 i_wdata,
    output logic [7:0]                      o_rdata,
    output logic                            o_rd_valid,
    output logic                            o_wr_refused,
    output logic                            o_array_err,
    input  wire logic                       i_fault_raw,
    output logic                            o_fault,
    input  wire logic                       i_crm_active,
    input  wire logic [7:0]                 i_src_enable,
    input  wire logic                       i_rsp_start,
    input  wire logic                       i_periodic_collection_mode_cmd_fall,
    input  wire logic                       i_psi5_slot,
    input  wire logic                       i_psi5_sync,
    input  wire logic                       i_spi_req,
    input  wire logic [2:0]                 i_spi_src,
    output logic                            o_sample_strobe,
    output logic [7:0]                      o_sample_mask,
    output ctc_pkg::ctc_chip_bit_time_s     o_chip,
    output ctc_pkg::ctc_timing_config_two_s       o_cfg2,
    output ctc_pkg::ctc_link_timing_s       o_timing
);

    // Whole module state in one register
    typedef struct packed {
        ctc_pkg::ctc_chip_bit_time_s chip;      // Chip and bit time
        ctc_pkg::ctc_timing_config_two_s   cfg2;      // Second timing config
        logic [7:0]                  sig;       // Stored array signature
        logic                        array_err; // Signature mismatch
        logic                        held;      // Latched internal fault
        logic                        fault;     // Reported fault
        logic [7:0]                  rdata;     // Read data
        logic                        rd_valid;  // Read answer pulse
        logic                        refused;   // Write dropped pulse
        logic                        strobe;    // Sample reference pulse
        logic [7:0]                  mask;      // Sources to refresh
        ctc_pkg::ctc_link_timing_s   timing;    // Registered link timing
    } ctc_state_s;

    ctc_state_s                st;          // Current state
    ctc_state_s                next_st;     // Next state
    ctc_pkg::ctc_link_timing_s dec_timing;  // Decoder output
    logic                      is_dsi3;     // Mode decodes
    logic                      is_psi5;
    logic                      is_spi;
    logic                      is_i2c;
    logic                      access_ok;   // Register port open
    logic                      latch_on;    // Fault latching active
    logic [2:0]                low_src;     // Lowest enabled slot
    logic                      sim_sel;     // Simultaneous selected

    assign is_dsi3 = (i_mode == ctc_pkg::CTC_DSI3);
    assign is_psi5 = (i_mode == ctc_pkg::CTC_PSI5);
    assign is_spi  = (i_mode == ctc_pkg::CTC_SPI);
    assign is_i2c  = (i_mode == ctc_pkg::CTC_I2C);
    assign sim_sel = st.chip.sim_sample_select;

    // Registers stay closed while PSI5 streams sensor data
    assign access_ok = !is_psi5 || i_psi5_prog_mode;
    assign latch_on  = is_psi5 && st.chip.fault_latch_enable;

    // Signature over both registers; any single-bit upset in between shows up
    function automatic logic [7:0] ctc_sign
    (
        input ctc_pkg::ctc_chip_bit_time_s c,
        input ctc_pkg::ctc_timing_config_two_s   t
    );
        logic [7:0] tv;
        tv = t;
        return c ^ {tv[0], tv[7:1]} ^ 8'hA5;
    endfunction : ctc_sign

    // Priority scan for the lowest enabled slot, top slot down so the lowest enabled slot wins
    function automatic logic [2:0] ctc_lowest
    (
        input logic [7:0] en
    );
        logic [2:0] r;
        r = 3'h0;
        for (int k = ctc_pkg::NUM_SRC - 1; k >= 0; k--)
        begin
            if (en[k])
            begin
                r = 3'(k);
            end
        end
        return r;
    endfunction : ctc_lowest

    assign low_src = ctc_lowest(i_src_enable);

    // Code to chip time lookup
    ctc_chip_decode u_decode
    (
        .i_mode       (i_mode),
        .i_crm_active (i_crm_active),
        .i_code       (st.chip.chip_period_code),
        .o_timing     (dec_timing)
    );

    // Next state
    always_comb
    begin
        next_st          = st;
        next_st.rd_valid = 1'b0;
        next_st.refused  = 1'b0;
        next_st.strobe   = 1'b0;
        next_st.timing   = dec_timing;

        // Register writes; unmapped or closed writes are dropped
        if (i_wr_en)
        begin
            if (!access_ok)
            begin
                next_st.refused = 1'b1;
            end
            else if (i_addr == ctc_pkg::ADDR_CHIP_BIT_TIME)
            begin
                next_st.chip = i_wdata;
            end
            else if (i_addr == ctc_pkg::ADDR_TIMING_CONFIG_TWO)
            begin
                // Reserved bit forced low on every write
                next_st.cfg2 = i_wdata & ctc_pkg::TC2_WRITE_MASK;
            end
            else
            begin
                next_st.refused = 1'b1;
            end
            // Reseal the signature after every write, refused ones included
            next_st.sig = ctc_sign(next_st.chip, next_st.cfg2);
        end

        // Register reads answer next cycle; closed or unmapped read zero
        if (i_rd_en)
        begin
            next_st.rd_valid = 1'b1;
            next_st.rdata    = 8'h00;
            if (access_ok && i_addr == ctc_pkg::ADDR_CHIP_BIT_TIME)
            begin
                next_st.rdata = st.chip;
            end
            else if (access_ok && i_addr == ctc_pkg::ADDR_TIMING_CONFIG_TWO)
            begin
                next_st.rdata = st.cfg2;
            end
        end

        // Array check compares the live bits with the sealed signature
        next_st.array_err = (ctc_sign(st.chip, st.cfg2) != st.sig);

        // Fault latching; only a reset clears the held copy
        if (latch_on && i_fault_raw)
        begin
            next_st.held = 1'b1;
        end
        // Outside PSI5 the raw fault clears itself as usual
        next_st.fault = i_fault_raw || (next_st.held && is_psi5);

        // Sample reference selection per protocol
        unique case (i_mode)
            ctc_pkg::CTC_DSI3:
            begin
                next_st.strobe = sim_sel ? i_periodic_collection_mode_cmd_fall
                                         : i_rsp_start;
                next_st.mask   = next_st.strobe ? i_src_enable : st.mask;
            end
            ctc_pkg::CTC_PSI5:
            begin
                next_st.strobe = sim_sel ? i_psi5_sync
                                         : i_psi5_slot;
                next_st.mask   = next_st.strobe ? i_src_enable : st.mask;
            end
            ctc_pkg::CTC_SPI:
            begin
                if (i_spi_req && i_src_enable[i_spi_src])
                begin
                    if (!sim_sel)
                    begin
                        // Each slot keeps its own time base
                        next_st.strobe = 1'b1;
                        next_st.mask   = 8'h01 << i_spi_src;
                    end
                    else if (i_spi_src == low_src)
                    begin
                        // One edge refreshes every enabled slot
                        next_st.strobe = 1'b1;
                        next_st.mask   = i_src_enable;
                    end
                    // Other slots keep stale data; the host must
                    // poll the lowest slot to refresh them
                end
            end
            ctc_pkg::CTC_I2C:
            begin
                next_st.strobe = 1'b0;
            end
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st      <= '0;
            st.chip <= ctc_pkg::RST_CHIP_BIT_TIME;
            st.cfg2 <= ctc_pkg::RST_TIMING_CONFIG_TWO;
            st.sig  <= ctc_sign(ctc_pkg::RST_CHIP_BIT_TIME,
                                ctc_pkg::RST_TIMING_CONFIG_TWO);
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign o_rdata         = st.rdata;
    assign o_rd_valid      = st.rd_valid;
    assign o_wr_refused    = st.refused;
    assign o_array_err     = st.array_err;
    assign o_fault         = st.fault;
    assign o_sample_strobe = st.strobe;
    assign o_sample_mask   = st.mask;
    assign o_chip          = st.chip;
    assign o_cfg2          = st.cfg2;
    assign o_timing        = st.timing;

    // Checks on the behaviour above
    default clocking ctc_cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_fault_latch_hold: assert property (
        st.held && is_psi5 |=> o_fault [*1] ##0 st.held)
        else $error("Latched fault not reported");
    a_fault_auto_clear: assert property (
        !is_psi5 && !i_fault_raw |=> !o_fault)
        else $error("Fault held outside PSI5 mode");
    a_dsi3_sync_ref: assert property (
        is_dsi3 && !sim_sel |=> o_sample_strobe == $past(i_rsp_start))
        else $error("DSI3 synchronous reference wrong");
    a_dsi3_sim_ref: assert property (
        is_dsi3 && sim_sel
        |=> o_sample_strobe == $past(i_periodic_collection_mode_cmd_fall))
        else $error("DSI3 simultaneous reference wrong");
    a_psi5_ref_sel: assert property (
        is_psi5 |=> o_sample_strobe ==
        ($past(sim_sel) ? $past(i_psi5_sync) : $past(i_psi5_slot)))
        else $error("PSI5 latency reference wrong");
    a_spi_own_ref: assert property (
        is_spi && !sim_sel && i_spi_req && i_src_enable[i_spi_src]
        |=> o_sample_strobe
            && o_sample_mask == (8'h01 << $past(i_spi_src)))
        else $error("SPI synchronous sample wrong");
    a_spi_low_ref: assert property (
        is_spi && sim_sel && i_spi_req && i_spi_src == low_src
        && i_src_enable[i_spi_src]
        |=> o_sample_strobe && o_sample_mask == $past(i_src_enable))
        else $error("SPI simultaneous sample wrong");
    a_spi_high_hold: assert property (
        is_spi && sim_sel && i_spi_src != low_src
        |=> !o_sample_strobe && $stable(o_sample_mask))
        else $error("Higher slot refreshed on own request");
    a_i2c_no_sample: assert property (
        is_i2c |=> !o_sample_strobe)
        else $error("Sample strobe in I2C mode");
    a_crm_chip_time: assert property (
        is_dsi3 && i_crm_active
        |=> o_timing.chip_cycles == 11'h3E8 && o_timing.slew_en)
        else $error("CRM chip time not 5 us");
    a_dsi3_slew_off: assert property (
        is_dsi3 && !i_crm_active && o_chip.chip_period_code < 4'h2
        |=> !o_timing.slew_en)
        else $error("Slew on for fast DSI3 code");
    a_psi5_bit_rate: assert property (
        is_psi5 |=> o_timing.slew_en && o_timing.chip_cycles ==
        ($past(o_chip.chip_period_code[3]) ? 11'h640 : 11'h424))
        else $error("PSI5 bit period wrong");
    a_spi_no_timing: assert property (
        is_spi || is_i2c |=> o_timing == '0)
        else $error("Chip code acted in SPI or I2C");
    a_cfg2_reserved: assert property (
        i_wr_en && access_ok && i_addr == ctc_pkg::ADDR_TIMING_CONFIG_TWO
        |=> !o_cfg2.reserved ##1 !o_array_err)
        else $error("Reserved bit stored or bad seal");
    a_write_closed: assert property (
        i_wr_en && is_psi5 && !i_psi5_prog_mode
        |=> o_wr_refused && $stable(o_chip) && $stable(o_cfg2))
        else $error("Write taken in PSI5 normal mode");

    c_spi_simul: cover property (
        is_spi && sim_sel && i_spi_req && i_spi_src == low_src ##1
        o_sample_strobe);
    c_fault_latched: cover property (
        latch_on && i_fault_raw ##1 !i_fault_raw ##1 o_fault);
    c_write_refused: cover property (o_wr_refused);
    c_psi5_slow: cover property (o_timing.psi5_slow_rate);

endmodule : ctc_timing_regs

// ==== tb/ctc_host_model.sv ====
// Host model: single byte register writes and reads.
// Assumes the device takes a request one edge after it is raised.
`timescale 1ns/1ps
module ctc_host_model
(
    input  wire logic       i_clk,
    input  wire logic       i_rd_valid,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_wr_refused,
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata
);
    // Bus idle until the first request
    initial
        {o_wr_en, o_rd_en, o_addr, o_wdata} = 18'h00000;
    // Released lines scramble so stale values never pass for data;
    // q is read data, or the refusal flag for a write
    task automatic xfer(input logic wr, input logic [7:0] a, d,
        output logic [7:0] q);
        @(posedge i_clk);
        o_wr_en <= wr;
        o_rd_en <= !wr;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_rd_en <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
        // Answer stands for the cycle after the taking edge; look 1 ns into it
        #1 q = wr ? {7'h00, i_wr_refused} : (i_rd_valid ? i_rdata : ~i_rdata);
    endtask : xfer
endmodule : ctc_host_model

// ==== tb/ctc_timing_regs_tb.sv ====
// Self-checking bench for the timing configuration registers.
// Register traffic goes through the host model; events are driven here.
`timescale 1ns/1ps
module ctc_timing_regs_tb;
    // DSI3 chip time per code, tenths of a microsecond
    localparam logic [5:0] TENTHS [16] = '{6'h0A, 6'h14, 6'h19, 6'h1A,
        6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h23,
        6'h28, 6'h2D, 6'h32};
    logic                        clk, rst, prog, crm, raw, wr_en, rd_en;
    logic                        rd_valid, wr_ref, strobe, fault, arr_err;
    logic [7:0]                  addr, wdata, rdata, rv, en, mask;
    logic [4:0]                  ev;  // Reference event pulses
    logic [2:0]                  src; // Slot of an SPI request
    ctc_pkg::ctc_mode_e          mode;
    ctc_pkg::ctc_chip_bit_time_s chip;
    ctc_pkg::ctc_timing_config_two_s   cfg2;
    ctc_pkg::ctc_link_timing_s   tim;
    int                          errors = 0, n_tests = 0, cycles = 0;
    integer                      seed = 32'hE6E1DB50;
    ctc_timing_regs i_ctc_timing_regs (.i_clk(clk), .i_rst(rst),
        .i_mode(mode), .i_psi5_prog_mode(prog), .i_wr_en(wr_en),
        .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .o_rd_valid(rd_valid), .o_wr_refused(wr_ref), .o_array_err(arr_err),
        .i_fault_raw(raw), .o_fault(fault), .i_crm_active(crm),
        .i_src_enable(en), .i_rsp_start(ev[0]), .i_periodic_collection_mode_cmd_fall(ev[1]),
        .i_psi5_slot(ev[2]), .i_psi5_sync(ev[3]), .i_spi_req(ev[4]),
        .i_spi_src(src), .o_sample_strobe(strobe), .o_sample_mask(mask),
        .o_chip(chip), .o_cfg2(cfg2), .o_timing(tim));
    ctc_host_model i_ctc_host_model (.i_clk(clk), .i_rd_valid(rd_valid),
        .i_rdata(rdata), .i_wr_refused(wr_ref), .o_wr_en(wr_en),
        .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Verdict and end of run
    task automatic complete_run;
        $display("errors %0d, comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // Hang guard; the run needs only a few hundred cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            complete_run();
        end
    end
    // Value compare; narrower results are zero-extended
    task automatic chk(input logic [12:0] got, exp);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    // Register access, answer checked against e
    task automatic acc(input logic wr, input logic [7:0] a, d, e);
        logic [7:0] q;
        i_ctc_host_model.xfer(wr, a, d, q);
        chk(13'(q), 13'(e));
    endtask : acc
    // Link timing for the current mode and command flag
    function automatic logic [12:0] tmg(input logic [3:0] k);
        if (mode == ctc_pkg::CTC_DSI3 && crm)
            return {11'h3E8, 2'b10};
        if (mode == ctc_pkg::CTC_DSI3)
            return {11'(TENTHS[k] * 20), k > 4'h1, 1'b0};
        if (mode == ctc_pkg::CTC_PSI5)
            return {(k[3] ? 11'h640 : 11'h424), 1'b1, k[3]};
        return 13'h0000;
    endfunction : tmg
    // Whether event e on slot k strobes under select s
    function automatic logic exp_stb(input int e, input logic [2:0] k,
        input logic s);
        case (mode)
            ctc_pkg::CTC_DSI3: return e == (s ? 1 : 0);
            ctc_pkg::CTC_PSI5: return e == (s ? 3 : 2);
            ctc_pkg::CTC_SPI:  return e == 4 && en[k] &&
                (!s || (en & ((8'h01 << k) - 8'h01)) == 8'h00);
            default:           return 1'b0;
        endcase
    endfunction : exp_stb
    // One event pulse; expectation taken once mode and enables settle
    task automatic fire(input int e, input logic [2:0] k, input logic s);
        logic x;
        @(posedge clk);
        x = exp_stb(e, k, s);
        ev <= 5'(1 << e);
        src <= k;
        @(posedge clk);
        ev <= 5'h00;
        src <= ~k;
        #1 chk(13'(strobe), 13'(x));
        if (x)
            chk(13'(mask), 13'((mode == ctc_pkg::CTC_SPI && !s) ?
                8'h01 << k : en));
    endtask : fire
    // Raw fault pulse; held tells whether it must outlive the pulse
    task automatic fpulse(input logic held);
        @(posedge clk);
        raw <= 1'b1;
        @(posedge clk);
        raw <= 1'b0;
        #1 chk(13'(fault), 13'h0001);
        repeat (3) @(posedge clk);
        #1 chk(13'(fault), 13'(held));
    endtask : fpulse
    // Main sequence
    initial
    begin
        {rst, prog, crm, raw, ev, src, en} = {1'b1, 19'h00000};
        mode = ctc_pkg::CTC_DSI3;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1 chk(13'(chip), 13'h0000);
        chk(13'(cfg2), 13'h0000);
        acc(1'b0, 8'h23, 8'h00, 8'h00);
        acc(1'b0, 8'h30, 8'h00, 8'h00);
        acc(1'b1, 8'h24, 8'hFF, 8'h00);
        acc(1'b0, 8'h24, 8'h00, 8'hFB);
        acc(1'b1, 8'h30, 8'h5A, 8'h01);
        prog <= 1'b1;
        // Every code in every mode, random upper bits and frame flag
        for (int i = 0; i < 64; i++)
        begin
            rv = 8'($random(seed));
            mode <= ctc_pkg::ctc_mode_e'(i[5:4]);
            crm <= rv[0];
            acc(1'b1, 8'h23, {rv[7:4], i[3:0]}, 8'h00);
            #1 chk(13'(chip), 13'({rv[7:4], i[3:0]}));
            // Timing follows the stored code one edge later
            @(posedge clk);
            #1 chk(13'(tim), tmg(i[3:0]));
        end
        // PSI5 normal mode closes the registers
        prog <= 1'b0;
        mode <= ctc_pkg::CTC_PSI5;
        acc(1'b1, 8'h24, 8'h00, 8'h01);
        acc(1'b0, 8'h24, 8'h00, 8'h00);
        #1 chk(13'(cfg2), 13'h00FB);
        mode <= ctc_pkg::CTC_DSI3;
        acc(1'b1, 8'h23, 8'h20, 8'h00);
        fpulse(1'b0);
        mode <= ctc_pkg::CTC_PSI5;
        fpulse(1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        fpulse(1'b0);
        prog <= 1'b1;
        // Reference events for each mode and select value
        for (int r = 0; r < 16; r++)
        begin
            acc(1'b1, 8'h23, {3'h0, r[0], 4'h0}, 8'h00);
            mode <= ctc_pkg::ctc_mode_e'(r[2:1]);
            en <= r[3] ? 8'($random(seed)) : 8'h0C;
            for (int e = 0; e < 5; e++)
            begin
                rv = 8'($random(seed));
                fire(e, rv[2:0], r[0]);
            end
        end
        // SPI corners: disabled slot, non-lowest slot, slot zero
        mode <= ctc_pkg::CTC_SPI;
        en <= 8'h0C;
        acc(1'b1, 8'h23, 8'h00, 8'h00);
        fire(4, 3'h1, 1'b0);
        fire(4, 3'h2, 1'b0);
        acc(1'b1, 8'h23, 8'h10, 8'h00);
        fire(4, 3'h3, 1'b1);
        fire(4, 3'h2, 1'b1);
        en <= 8'h0D;
        fire(4, 3'h0, 1'b1);
        chk(13'(arr_err), 13'h0000);
        complete_run();
    end
endmodule : ctc_timing_regs_tb
